// ===== design/pll_scan_reconfig_controller.sv
`timescale 1ns/1ps
`include "pll_reconf_map.svh"
// Overview of operation
// RL1: Divide-by-one on n or m: nominal count all zero, bypass bit one.
// RL2: Output divider bypass bit one bypasses it; other bits ignored.
// RL3: Source never pairs n/m bypass one with count LSB one.
// RL4: Long chain: shift clock stops on its 289th falling edge.
// RL5: Serial data to the PLL changes on shift clock falling edges.
// RL6: Clear pulse at start-up and before every reconfiguration.
// RL7: Chain setting selects 289-bit or 193-bit cache and shift length.
// RL8: Cache starts from a preload image matching the chain length.
// RL9: One clock times field access and shift clock generation.
// RL10: Nine-bit write value; narrow fields use only low bits.
// RL11: Counter select: type in upper bits, index lower; e only long.
// RL12: Field select upper bits give width: 9, 4 or 1 bit.
// RL13: Read request sampled on rising edge starts a field fetch.
// RL14: Busy rises on read and holds; read value valid when busy drops.
// RL15: User pulses read or write request for exactly one cycle.
// RL16: Write request sampled on rising edge stores value into field.
// RL17: Busy during write; value bus changes ignored; busy drops when stored.
// RL18: Apply shifts whole cache into PLL under busy; cache unchanged.
// RL19: While busy all requests and selects are ignored.
// RL20: Asynchronous reset puts the controller in a valid idle state.
// RL21: Cache shifted MSB first; chain bit 0 goes last.
// RL22: Illegal select codes leave cache alone; busy for one cycle.
// RL23: Busy through the whole shift; no new apply until it ends.

// ----------------------------------------------------------------------
// Bit stream buffer
// ----------------------------------------------------------------------
module stream_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int DEPTH_I = DEPTH;
  localparam logic [AW:0] FULL = DEPTH_I[AW:0];

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } fifo_t;

  fifo_t q;
  fifo_t d;

  assign in_ready  = (q.wr - q.rd) != FULL;
  assign out_valid = q.wr != q.rd;
  assign out_data  = q.mem[q.rd[AW-1:0]];

  always_comb begin
    d = q;
    if (in_valid && in_ready) begin
      d.mem[q.wr[AW-1:0]] = in_data;
      d.wr = q.wr + 1'b1;
    end
    if (out_valid && out_ready) begin
      d.rd = q.rd + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ----------------------------------------------------------------------
// Controller
// ----------------------------------------------------------------------
module pll_scan_reconfig_controller
  import pll_reconf_pkg::*;
#(
  parameter bit           LONG_CHAIN = 1'b1,
  parameter logic [288:0] INIT_IMAGE = `INIT_IMAGE_DEF,
  parameter int           FIFO_DEPTH = 16
) (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire user_req_t  req,
  output logic            busy,
  output logic [8:0]      rd_val,
  output scan_pins_t      scan
);
  // Cache size and shift length follow the chain setting
  localparam int LEN = LONG_CHAIN ? `CHAIN_LEN_LONG : `CHAIN_LEN_SHORT; // RL7
  localparam logic [8:0] LEN_W = LEN[8:0];
  localparam int CLR_CYC = `SCAN_CLR_CYC;
  localparam logic [3:0] CLR_LAST = 4'(CLR_CYC - 1);

  typedef struct packed {
    ctl_state_t     st;
    logic           busy;
    logic [8:0]     rd_val;
    scan_pins_t     scan;
    logic [LEN-1:0] cache;
    logic [8:0]     base;
    logic [3:0]     width;
    logic [8:0]     wval;
    logic [3:0]     clr_cnt;
    logic [8:0]     feed_cnt;
    logic [8:0]     sent;
    logic           loaded;
  } regs_t;

  regs_t      q;
  regs_t      d;
  logic       sel_legal;
  logic [3:0] slot;
  logic [4:0] fofs;
  logic [3:0] fwid;
  logic [8:0] sel_base;
  logic       f_in_valid;
  logic       f_in_data;
  logic       f_in_ready;
  logic       f_out_valid;
  logic       f_out_data;
  logic       f_out_ready;

  // --------------------------------------------------------------------
  // Select decode
  // --------------------------------------------------------------------
  always_comb begin
    sel_legal = 1'b1;
    slot      = 4'h0;
    fofs      = `OFS_COUNT_A;
    fwid      = 4'h0;
    unique case (req.cnt_sel[3:2]) // RL11
      `TYPE_NM: begin
        slot      = {2'b00, req.cnt_sel[1:0]};
        sel_legal = !req.cnt_sel[1];
      end
      `TYPE_G: begin
        slot = `SLOT_G + {2'b00, req.cnt_sel[1:0]};
      end
      `TYPE_L: begin
        slot      = `SLOT_L + {2'b00, req.cnt_sel[1:0]};
        sel_legal = !req.cnt_sel[1];
      end
      `TYPE_E: begin
        slot      = `SLOT_E + {2'b00, req.cnt_sel[1:0]};
        sel_legal = LONG_CHAIN;
      end
    endcase
    // Bypass bits sit at fixed slot offsets; divide-by-one needs the
    // nominal count cleared as well, which the preload image provides
    unique case (req.fld_sel) // RL12 RL1 RL2
      `FLD_COUNT_A: begin fofs = `OFS_COUNT_A; fwid = `W_WIDE;  end
      `FLD_COUNT_B: begin fofs = `OFS_COUNT_B; fwid = `W_WIDE;  end
      `FLD_DELAY:   begin fofs = `OFS_DELAY;   fwid = `W_DELAY; end
      `FLD_BYPASS:  begin fofs = `OFS_BYPASS;  fwid = `W_BIT;   end
      `FLD_AUX_BIT: begin fofs = `OFS_AUX_BIT; fwid = `W_BIT;   end
      default:      sel_legal = 1'b0;
    endcase
    sel_base = 9'(slot * `SLOT_BITS + fofs);
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    d           = q;
    f_in_valid  = 1'b0;
    f_in_data   = 1'b0;
    f_out_ready = 1'b0;
    unique case (q.st)
      ST_INIT, ST_CLR: begin
        if (q.clr_cnt == CLR_LAST) begin
          d.st = (q.st == ST_INIT) ? ST_IDLE : ST_SHIFT; // RL20
        end else begin
          d.clr_cnt = q.clr_cnt + 4'h1;
        end
      end
      ST_IDLE: begin
        // Selects and value are captured here, so later changes are moot
        if (req.apply) begin
          d.st       = ST_CLR; // RL6 RL18
          d.clr_cnt  = 4'h0;
          d.feed_cnt = 9'h000;
          d.sent     = 9'h000;
          d.loaded   = 1'b0;
        end else if (req.wr || req.rd) begin // RL13 RL16 RL17
          d.st    = (req.rd && !req.wr && sel_legal) ? ST_RD : ST_WR;
          d.base  = sel_base;
          d.width = sel_legal ? fwid : 4'h0; // RL22
          d.wval  = req.wr_val;
        end
      end
      ST_RD: begin
        for (int i = 0; i < 9; i++) begin
          d.rd_val[i] = (4'(i) < q.width) ? q.cache[9'(q.base + 9'(i))]
                                          : 1'b0; // RL10
        end
        d.st = ST_IDLE;
      end
      ST_WR: begin
        for (int i = 0; i < 9; i++) begin
          if (4'(i) < q.width) begin
            d.cache[9'(q.base + 9'(i))] = q.wval[i]; // RL10
          end
        end
        d.st = ST_IDLE;
      end
      ST_SHIFT: begin
        // Feeder runs one bit a cycle; the two-cycle shift clock drains
        // slower, so the buffer fills and the feeder stalls on it
        f_in_valid = q.feed_cnt < LEN_W;
        f_in_data  = q.cache[9'(LEN_W - 9'h001 - q.feed_cnt)]; // RL21
        if (f_in_valid && f_in_ready) begin
          d.feed_cnt = q.feed_cnt + 9'h001;
        end
        if (q.scan.clk) begin
          d.scan.clk = 1'b0;
          d.loaded   = 1'b0;
          if (q.sent == LEN_W) begin
            d.st = ST_IDLE; // RL4 RL23
          end else if (f_out_valid) begin
            f_out_ready = 1'b1;
            d.scan.data = f_out_data; // RL5
            d.loaded    = 1'b1;
          end
        end else if (q.loaded) begin
          d.scan.clk = 1'b1;
          d.sent     = q.sent + 9'h001;
          d.loaded   = 1'b0;
        end else if (f_out_valid) begin
          // Only the first bit is set while the clock idles low
          f_out_ready = 1'b1;
          d.scan.data = f_out_data;
          d.loaded    = 1'b1;
        end
      end
    endcase
    d.scan.clr = (d.st == ST_INIT) || (d.st == ST_CLR); // RL6
    d.busy     = d.st != ST_IDLE; // RL14 RL17 RL19 RL23
  end

  // One clock for field access and shift clock, divided by two: 20 MHz
  always_ff @(posedge core_clk or negedge arst_n) begin // RL9
    if (!arst_n) begin
      q          <= '0;
      q.st       <= ST_INIT;
      q.busy     <= 1'b1;
      q.scan.clr <= 1'b1;
      q.cache    <= INIT_IMAGE[LEN-1:0]; // RL8
    end else begin
      q <= d;
    end
  end

  stream_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (f_in_valid),
    .in_data   (f_in_data),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (f_out_ready)
  );

  assign busy   = q.busy;
  assign rd_val = q.rd_val;
  assign scan   = q.scan;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic       chk_clk_q;
  logic [8:0] chk_falls_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_clk_q   <= 1'b0;
      chk_falls_q <= 9'h000;
    end else begin
      chk_clk_q <= q.scan.clk;
      if (q.scan.clr) begin
        chk_falls_q <= 9'h000;
      end else if (chk_clk_q && !q.scan.clk) begin
        chk_falls_q <= chk_falls_q + 9'h001;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_rd_busy;
    !q.busy && req.rd && !req.wr && !req.apply && sel_legal
      |=> q.busy ##1 !q.busy;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read busy"); // RL14

  property p_wr_store;
    !q.busy && req.wr && !req.apply && sel_legal && fwid == `W_WIDE
      |=> q.busy ##1 (!q.busy && q.cache[q.base +: 9] == q.wval);
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("write lost"); // RL17

  property p_illegal;
    !q.busy && (req.rd || req.wr) && !req.apply && !sel_legal
      |=> q.busy ##1 (!q.busy && $stable(q.cache) && $stable(q.rd_val));
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal op"); // RL22

  property p_narrow_read;
    !q.busy && req.rd && !req.wr && !req.apply && sel_legal &&
      fwid == `W_DELAY |=> ##1 q.rd_val[8:4] == 5'h00;
  endproperty
  a_narrow_read: assert property (p_narrow_read) else $error("wide read"); // RL10

  property p_apply_clear;
    !q.busy && req.apply |=> q.scan.clr && q.busy;
  endproperty
  a_apply_clear: assert property (p_apply_clear) else $error("no clear"); // RL6

  property p_data_on_fall;
    q.scan.clk |-> $stable(q.scan.data);
  endproperty
  a_data_on_fall: assert property (p_data_on_fall) else $error("data edge"); // RL5

  property p_fall_count;
    q.st == ST_SHIFT ##1 q.st == ST_IDLE |-> ##2 chk_falls_q == LEN_W;
  endproperty
  a_fall_count: assert property (p_fall_count) else $error("fall count"); // RL4

  property p_msb_first;
    $rose(q.scan.clk) && chk_falls_q == 9'h000
      |-> q.scan.data == q.cache[LEN-1];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("order"); // RL21

  property p_shift_busy;
    q.scan.clk |-> q.busy && q.st == ST_SHIFT;
  endproperty
  a_shift_busy: assert property (p_shift_busy) else $error("idle shift"); // RL23

  property p_cache_hold;
    q.busy && q.st != ST_WR |=> $stable(q.cache);
  endproperty
  a_cache_hold: assert property (p_cache_hold) else $error("cache moved"); // RL18
endmodule

// ===== design/pll_reconf_map.svh
`ifndef PLL_RECONF_MAP_SVH
`define PLL_RECONF_MAP_SVH

// ----------------------------------------------------------------------
// Chain geometry
// ----------------------------------------------------------------------
`define CHAIN_LEN_LONG   289
`define CHAIN_LEN_SHORT  193
`define SLOT_BITS        24
`define SLOT_G           4'h2
`define SLOT_L           4'h6
`define SLOT_E           4'h8

// ----------------------------------------------------------------------
// Counter select upper bits
// ----------------------------------------------------------------------
`define TYPE_NM          2'h0
`define TYPE_G           2'h1
`define TYPE_L           2'h2
`define TYPE_E           2'h3

// ----------------------------------------------------------------------
// Field select codes, offsets inside a slot and widths
// ----------------------------------------------------------------------
`define FLD_COUNT_A      3'h0
`define FLD_COUNT_B      3'h1
`define FLD_DELAY        3'h2
`define FLD_BYPASS       3'h4
`define FLD_AUX_BIT      3'h5
`define OFS_COUNT_A      5'h00
`define OFS_BYPASS       5'h09
`define OFS_COUNT_B      5'h0a
`define OFS_AUX_BIT      5'h13
`define OFS_DELAY        5'h14
`define W_WIDE           4'h9
`define W_DELAY          4'h4
`define W_BIT            4'h1

// ----------------------------------------------------------------------
// Preload image: n and m bypassed with zero nominal count (divide by one)
// ----------------------------------------------------------------------
`define INIT_IMAGE_DEF   289'h2_0000_0200

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS    25000
`define SCAN_CLR_MIN_PS  5000
`define SCAN_CLR_RAW     ((`SCAN_CLR_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SCAN_CLR_CYC     ((`SCAN_CLR_RAW < 1) ? 1 : `SCAN_CLR_RAW)

`endif

// ===== design/pll_reconf_pkg.sv
package pll_reconf_pkg;

  typedef enum logic [5:0] {
    ST_INIT  = 6'h01,
    ST_IDLE  = 6'h02,
    ST_RD    = 6'h04,
    ST_WR    = 6'h08,
    ST_CLR   = 6'h10,
    ST_SHIFT = 6'h20
  } ctl_state_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       apply;
    logic [3:0] cnt_sel;
    logic [2:0] fld_sel;
    logic [8:0] wr_val;
  } user_req_t;

  typedef struct packed {
    logic clk;
    logic data;
    logic clr;
  } scan_pins_t;

endpackage

// ===== bench/scan_chain_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// PLL scan chain: shifts on rising edges, cleared by clr
// ---------------------------------------------------------------
module scan_chain_model
  import pll_reconf_pkg::*;
(
  input  wire scan_pins_t scan,
  output logic [288:0]    chain,
  output int              rises,
  output int              clears,
  output int              skews
);
  initial begin
    chain = '0;
    rises = 0;
    clears = 0;
    skews = 0;
  end

  always @(posedge scan.clr) begin
    chain  <= '0;
    rises  <= 0;
    clears <= clears + 1;
  end

  // Clr is asynchronous in the real chain, so it blocks shifting
  always @(posedge scan.clk) begin
    if (scan.clr === 1'b0) begin
      chain <= {chain[287:0], scan.data};
      rises <= rises + 1;
    end
  end

  // Judged one step later, once a same-step clock fall has landed
  always @(scan.data) begin
    #1;
    if (scan.clk === 1'b1)
      skews <= skews + 1;
  end
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench for the scan reconfiguration controller
// ---------------------------------------------------------------
module tb
  import pll_reconf_pkg::*;
;
  // Top chain bit set so the first shifted bit is visible
  localparam logic [288:0] IMG = (289'h1 << 288) | (289'h5a << 48)
                                 | 289'h2_0000_0200;
  logic         core_clk    = 1'b0;
  logic         arst_n      = 1'b0;
  user_req_t    req         = '0;
  logic         busy;
  logic [8:0]   rd_val;
  scan_pins_t   scan;
  logic [288:0] chain;
  int           rises;
  int           clears;
  int           skews;
  logic [288:0] exp_q       = IMG;
  logic [8:0]   last_rd     = '0;
  int           failures    = 0;
  int           check_count = 0;
  int           cyc         = 0;
  // No n or m bypass is paired with a count LSB of one
  logic [3:0] wc [8] = '{4'h0, 4'h5, 4'h9, 4'hf, 4'h1, 4'hc, 4'h6, 4'h1};
  logic [2:0] wf [8] = '{3'h1, 3'h0, 3'h5, 3'h2, 3'h4, 3'h4, 3'h2, 3'h0};
  logic [8:0] wv [8] = '{9'h155, 9'h1a3, 9'h001, 9'h1f6, 9'h000, 9'h1ff,
                         9'h1f4, 9'h0fe};
  logic [3:0] ic [7] = '{4'h2, 4'h3, 4'ha, 4'hb, 4'h4, 4'h4, 4'h4};
  logic [2:0] jf [7] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

  always #12.5 core_clk = ~core_clk;

  pll_scan_reconfig_controller #(.LONG_CHAIN(1'b1), .INIT_IMAGE(IMG),
    .FIFO_DEPTH(16)) dut (.core_clk(core_clk), .arst_n(arst_n),
    .req(req), .busy(busy), .rd_val(rd_val), .scan(scan));
  scan_chain_model pll_chain (.scan(scan), .chain(chain), .rises(rises),
    .clears(clears), .skews(skews));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [288:0] got, input logic [288:0] want);
    check_count++;
    if (got !== want) begin
      failures++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, want);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic int wid(input logic [2:0] f);
    case (f)
      3'h0, 3'h1: return 9;
      3'h2: return 4;
      3'h4, 3'h5: return 1;
      default: return 0;
    endcase
  endfunction

  function automatic int base(input logic [3:0] c, input logic [2:0] f);
    int s;
    int o;
    case (c[3:2])
      2'h0: s = c[1] ? -1 : int'(c[0]);
      2'h2: s = c[1] ? -1 : 6 + int'(c[0]);
      default: s = (c[3] ? 8 : 2) + int'(c[1:0]);
    endcase
    o = (f == 3'h1) ? 10 : (f == 3'h2) ? 20 : (f == 3'h4) ? 9 :
        (f == 3'h5) ? 19 : 0;
    return (s < 0 || wid(f) == 0) ? -1 : s * 24 + o;
  endfunction

  task automatic wait_idle(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 1000);
  endtask

  // Selects and value are scrambled while busy; they must not matter
  task automatic access(input logic [2:0] k, input logic [3:0] c,
                        input logic [2:0] f, input logic [8:0] v,
                        output int n);
    @(posedge core_clk);
    req <= '{rd: k[0], wr: k[1], apply: k[2], cnt_sel: c, fld_sel: f,
             wr_val: v};
    @(posedge core_clk);
    req <= '{rd: 1'b0, wr: 1'b0, apply: 1'b0, cnt_sel: ~c, fld_sel: ~f,
             wr_val: ~v};
    #1;
    chk(busy, 1'b1);
    wait_idle(n);
  endtask

  task automatic wr_op(input logic [3:0] c, input logic [2:0] f,
                       input logic [8:0] v);
    int n;
    int b;
    b = base(c, f);
    access(3'b010, c, f, v, n);
    chk(n, 1);
    if (b >= 0)
      for (int i = 0; i < wid(f); i++)
        exp_q[b + i] = v[i];
  endtask

  task automatic rd_op(input logic [3:0] c, input logic [2:0] f);
    int n;
    int b;
    b = base(c, f);
    access(3'b001, c, f, 9'h000, n);
    chk(n, 1);
    if (b >= 0) begin
      last_rd = '0;
      for (int i = 0; i < wid(f); i++)
        last_rd[i] = exp_q[b + i];
    end
    chk(rd_val, last_rd);
  endtask

  task automatic ap_check(input int n, input int c0);
    chk(n < 1000, 1'b1);
    chk(chain, exp_q);
    chk(rises, 289);
    chk(clears - c0, 1);
    chk(scan.clk, 1'b0);
    chk(skews, 0);
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    int n;
    int c0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk({busy, scan.clr}, 2'b00);
    rd_op(4'h0, 3'h4);
    rd_op(4'h4, 3'h0);
    for (int i = 0; i < 8; i++)
      wr_op(wc[i], wf[i], wv[i]);
    for (int i = 0; i < 8; i++)
      rd_op(wc[i], wf[i]);
    for (int i = 0; i < 7; i++) begin
      wr_op(ic[i], jf[i], 9'h1ff);
      rd_op(ic[i], jf[i]);
    end
    c0 = clears;
    @(posedge core_clk);
    req.apply <= 1'b1;
    @(posedge core_clk);
    req.apply <= 1'b0;
    repeat (6) @(posedge core_clk);
    req <= '{rd: 1'b0, wr: 1'b1, apply: 1'b1, cnt_sel: 4'h4,
             fld_sel: 3'h0, wr_val: 9'h0ff};
    @(posedge core_clk);
    req <= '0;
    wait_idle(n);
    ap_check(n, c0);
    rd_op(4'h4, 3'h0);
    c0 = clears;
    access(3'b100, 4'h0, 3'h0, 9'h000, n);
    ap_check(n, c0);
    // The bit buffer is exercised through two full shifts above;
    // the cache must still read back unchanged after them
    for (int i = 0; i < 8; i++)
      rd_op(wc[i], wf[i]);
    final_report();
  end
endmodule
